// [ftm_far_side.sv]
// writer and reader model that drives the fifo pins from the far side
`timescale 1ns/10ps
module ftm_far_side #(
  parameter int unsigned WIDTH = ftm_pkg::DEF_WIDTH
) (
  // clock
  input  wire logic             ref_clk_in,
  // control pins toward the fifo
  output logic                  master_reset_n_out,
  output logic                  mode_sel_out,
  // write and read pins
  output logic                  wr_en_n_out,
  output logic      [WIDTH-1:0] wr_data_out,
  output logic                  rd_en_n_out
);
  int unsigned wr_seq;

  // start inside master reset with both enables idle
  initial begin
    master_reset_n_out = 1'b0;
    mode_sel_out       = 1'b0;
    wr_en_n_out        = 1'b1;
    wr_data_out        = '0;
    rd_en_n_out        = 1'b1;
    wr_seq             = 0;
  end

  task automatic mreset(input logic ft);
    @(posedge ref_clk_in);
    mode_sel_out       <= ft;
    master_reset_n_out <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    master_reset_n_out <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
  endtask

  task automatic write_words(input int unsigned n);
    for (int unsigned i = 0; i < n; i++) begin
      @(posedge ref_clk_in);
      wr_en_n_out <= 1'b0;
      wr_data_out <= {4'h5, 32'(wr_seq)};
      wr_seq++;
    end
    @(posedge ref_clk_in);
    wr_en_n_out <= 1'b1;
    // released data must not look like a held word
    wr_data_out <= ~wr_data_out;
  endtask

  task automatic read_one();
    @(posedge ref_clk_in);
    rd_en_n_out <= 1'b0;
    @(posedge ref_clk_in);
    rd_en_n_out <= 1'b1;
  endtask
endmodule

// [ftm_fifo_flags.sv]
// fifo core with standard and fall-through timing modes and status flags
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
// ****************************************
// Overview of operation
// [R1] mode pin sampled during master reset
// [R2] standard mode reads need read enable
// [R3] fall-through first word after three edges
// [R4] write enable low captures input word
// [R5] standard empty flag rises after write
// [R6] standard almost-empty high from n+1 words
// [R7] standard half flag low above half
// [R8] standard almost-full low at D-m
// [R9] standard full at D, writes ignored
// [R10] standard first read releases full
// [R11] standard almost-empty low at n words
// [R12] standard last read empties, reads ignored
// [R13] standard empty/full two register stages
// [R14] fall-through output ready low when presented
// [R15] fall-through almost-empty high at n+2
// [R16] fall-through half flag above half+1
// [R17] fall-through almost-full at D+1-m
// [R18] fall-through input space blocks at D+1
// [R19] fall-through first read frees input
// [R20] fall-through almost-empty low at n+1
// [R21] fall-through last read, output ready high
// [R22] output ready three, input two stages
// [R23] offsets reload at master reset, writable
// [R24] depth parameter, thresholds derived from it
// ****************************************
module ftm_fifo_flags #(
  parameter int unsigned DEPTH = ftm_pkg::DEF_DEPTH,
  parameter int unsigned WIDTH = ftm_pkg::DEF_WIDTH
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  // master reset and mode pins
  input  wire logic             master_reset_n_in,
  input  wire logic             fall_through_select_serial_in_in,
  // write side
  input  wire logic             wr_en_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read side
  input  wire logic             rd_en_n_in,
  output logic      [WIDTH-1:0] data_out_out,
  // flags
  output logic                  empty_flag_n_out,
  output logic                  output_ready_n_out,
  output logic                  full_flag_n_out,
  output logic                  input_space_n_out,
  output logic                  half_level_flag_n_out,
  output logic                  almost_empty_flag_n_out,
  output logic                  almost_full_flag_n_out,
  // wishbone slave
  input  wire logic             wb_cyc_in,
  input  wire logic             wb_stb_in,
  input  wire logic             wb_we_in,
  input  wire logic [7:0]       wb_adr_in,
  input  wire logic [3:0]       wb_sel_in,
  input  wire logic [31:0]      wb_dat_in,
  output logic      [31:0]      wb_dat_out,
  output logic                  wb_ack_out
);

  // ****************************************
  // sizes and elaboration check
  // ****************************************
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;
  localparam logic [16:0] D17 = 17'(DEPTH);
  localparam logic [16:0] HALF17 = 17'(DEPTH / 2);

  // [R24] depth limited to powers of two in range
  generate
    if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < ftm_pkg::MIN_DEPTH || DEPTH > ftm_pkg::MAX_DEPTH) begin : g_bad
      $error("depth must be a power of two from 1024 to 32768");
    end
  endgenerate

  // widen a count to the threshold width
  function automatic logic [16:0] ftm_wide(input logic [CW-1:0] v);
    ftm_wide = 17'(v);
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] mrs_sync_ff;
  logic [1:0] mode_sync_ff;
  logic       mrs_n;

  // master reset and mode come from pins, so two flops first
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mrs_sync_ff  <= 2'h0;
      mode_sync_ff <= 2'h0;
    end else begin
      mrs_sync_ff  <= {mrs_sync_ff[0], master_reset_n_in};
      mode_sync_ff <= {mode_sync_ff[0], fall_through_select_serial_in_in};
    end
  end
  assign mrs_n = mrs_sync_ff[1];

  // ****************************************
  // mode latch
  // ****************************************
  logic fall_through_mode_ff;

  // [R1] tracks the pin only while master reset is held
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fall_through_mode_ff <= 1'b0;
    end else if (!mrs_n) begin
      fall_through_mode_ff <= mode_sync_ff[1];
    end
  end

  // ****************************************
  // storage, pointers and count
  // ****************************************
  logic [WIDTH-1:0]      mem [DEPTH];
  logic [AW-1:0]         wr_ptr_ff;
  logic [AW-1:0]         rd_ptr_ff;
  logic [CW-1:0]         mem_cnt_ff;
  ftm_pkg::ftm_ft_state_t ft_state_ff;
  ftm_pkg::ftm_ft_state_t nxt_ft_state;
  logic                  mem_full;
  logic                  mem_empty;
  logic                  wr_go;
  logic                  rd_req;
  logic                  pop;
  logic [CW-1:0]         level;

  assign mem_full  = (mem_cnt_ff == CW'(DEPTH));
  assign mem_empty = (mem_cnt_ff == '0);
  // [R9] writes ignored while the array is full
  assign wr_go = !wr_en_n_in && !mem_full && mrs_n;
  // [R12] [R21] read enable ignored when nothing to read
  assign rd_req = !rd_en_n_in && mrs_n &&
                  (fall_through_mode_ff ? (ft_state_ff == ftm_pkg::FTM_FT_VALID) : !mem_empty);
  // array pop: standard read, fall-through load, or refill on read
  assign pop = fall_through_mode_ff ?
               ((ft_state_ff == ftm_pkg::FTM_FT_W2) || (rd_req && !mem_empty)) : rd_req;
  // fall-through counts the output register too
  assign level = mem_cnt_ff + CW'(fall_through_mode_ff && ft_state_ff == ftm_pkg::FTM_FT_VALID);

  // [R4] word captured on each edge with write enable low, unless full or in master reset
  always_ff @(posedge ref_clk_in) begin
    if (wr_go) begin
      mem[wr_ptr_ff] <= wr_data_in;
    end
  end

  // pointers and count, cleared by master reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      mem_cnt_ff <= '0;
    end else if (!mrs_n) begin
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      mem_cnt_ff <= '0;
    end else begin
      if (wr_go) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      mem_cnt_ff <= mem_cnt_ff + CW'(wr_go) - CW'(pop);
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  // [R3] idle, two waits, then the word falls onto the outputs
  always_comb begin
    nxt_ft_state = ft_state_ff;
    case (ft_state_ff)
      ftm_pkg::FTM_FT_IDLE: begin
        if (!mem_empty) begin
          nxt_ft_state = ftm_pkg::FTM_FT_W1;
        end
      end
      ftm_pkg::FTM_FT_W1: nxt_ft_state = ftm_pkg::FTM_FT_W2;
      ftm_pkg::FTM_FT_W2: nxt_ft_state = ftm_pkg::FTM_FT_VALID;
      ftm_pkg::FTM_FT_VALID: begin
        if (rd_req && mem_empty) begin
          nxt_ft_state = ftm_pkg::FTM_FT_IDLE;
        end
      end
      default: nxt_ft_state = ftm_pkg::FTM_FT_IDLE;
    endcase
  end

  // standard mode never leaves idle
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ft_state_ff <= ftm_pkg::FTM_FT_IDLE;
    end else if (!mrs_n || !fall_through_mode_ff) begin
      ft_state_ff <= ftm_pkg::FTM_FT_IDLE;
    end else begin
      ft_state_ff <= nxt_ft_state;
    end
  end

  // [R2] data moves out only on a popped word
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_out_out <= '0;
    end else if (pop) begin
      data_out_out <= mem[rd_ptr_ff];
    end
  end

  // ****************************************
  // offset registers and wishbone slave
  // ****************************************
  logic [15:0]         empty_ofs_ff;
  logic [15:0]         full_ofs_ff;
  logic                wb_hit;
  ftm_pkg::ftm_status_t status;

  // one wait state: ack rises the edge after the strobe, then drops
  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_hit;
    end
  end

  // [R23] defaults reload on master reset, software may rewrite
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      empty_ofs_ff <= ftm_pkg::DEF_OFFSET;
      full_ofs_ff  <= ftm_pkg::DEF_OFFSET;
    end else if (!mrs_n) begin
      empty_ofs_ff <= ftm_pkg::DEF_OFFSET;
      full_ofs_ff  <= ftm_pkg::DEF_OFFSET;
    end else if (wb_hit && wb_we_in) begin
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_in[b] && wb_adr_in == ftm_pkg::ADR_EMPTY_OFS) begin
          empty_ofs_ff[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
        end
        if (wb_sel_in[b] && wb_adr_in == ftm_pkg::ADR_FULL_OFS) begin
          full_ofs_ff[b*8 +: 8] <= wb_dat_in[b*8 +: 8];
        end
      end
    end
  end

  assign status.fall_through_mode = fall_through_mode_ff;
  assign status.flags = '{in_space_n: input_space_n_out, out_ready_n: output_ready_n_out,
                          full_n: full_flag_n_out, almost_full_n: almost_full_flag_n_out,
                          half_n: half_level_flag_n_out, almost_empty_n: almost_empty_flag_n_out,
                          empty_n: empty_flag_n_out};

  // read data registered with the ack; unmapped reads give zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_dat_out <= ftm_pkg::RD_UNMAPPED;
    end else if (wb_hit && !wb_we_in) begin
      case (wb_adr_in)
        ftm_pkg::ADR_EMPTY_OFS: wb_dat_out <= {16'h0000, empty_ofs_ff};
        ftm_pkg::ADR_FULL_OFS:  wb_dat_out <= {16'h0000, full_ofs_ff};
        ftm_pkg::ADR_STATUS:    wb_dat_out <= 32'(status);
        ftm_pkg::ADR_LEVEL:     wb_dat_out <= 32'(level);
        default:                wb_dat_out <= ftm_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ****************************************
  // flags
  // ****************************************
  logic [16:0] ae_thr;
  logic [16:0] hf_thr;
  logic [16:0] af_thr;
  logic        empty_stage_ff;
  logic        full_stage_ff;

  // [R6] [R15] [R7] [R16] [R8] [R17] thresholds shift by one in fall-through
  assign ae_thr = 17'(empty_ofs_ff) + 17'h00001 + 17'(fall_through_mode_ff);
  assign hf_thr = HALF17 + 17'(fall_through_mode_ff);
  assign af_thr = D17 + 17'(fall_through_mode_ff) - 17'(full_ofs_ff);

  // [R11] [R20] [R7] [R8] level flags, one register after the count
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      almost_empty_flag_n_out <= ftm_pkg::FLAGS_RESET.almost_empty_n;
      half_level_flag_n_out   <= ftm_pkg::FLAGS_RESET.half_n;
      almost_full_flag_n_out  <= ftm_pkg::FLAGS_RESET.almost_full_n;
    end else if (!mrs_n) begin
      almost_empty_flag_n_out <= ftm_pkg::FLAGS_RESET.almost_empty_n;
      half_level_flag_n_out   <= ftm_pkg::FLAGS_RESET.half_n;
      almost_full_flag_n_out  <= ftm_pkg::FLAGS_RESET.almost_full_n;
    end else begin
      almost_empty_flag_n_out <= (ftm_wide(level) >= ae_thr);
      half_level_flag_n_out   <= !(ftm_wide(level) > hf_thr);
      almost_full_flag_n_out  <= !(ftm_wide(level) >= af_thr);
    end
  end

  // [R13] [R22] empty and full/input-space through two stages
  // the gating above uses the live count, so the flag lag never overruns
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      empty_stage_ff    <= 1'b0;
      full_stage_ff     <= 1'b0;
      empty_flag_n_out  <= ftm_pkg::FLAGS_RESET.empty_n;
      full_flag_n_out   <= ftm_pkg::FLAGS_RESET.full_n;
      input_space_n_out <= ftm_pkg::FLAGS_RESET.in_space_n;
    end else if (!mrs_n) begin
      empty_stage_ff    <= 1'b0;
      full_stage_ff     <= 1'b0;
      empty_flag_n_out  <= ftm_pkg::FLAGS_RESET.empty_n;
      full_flag_n_out   <= ftm_pkg::FLAGS_RESET.full_n;
      input_space_n_out <= ftm_pkg::FLAGS_RESET.in_space_n;
    end else begin
      empty_stage_ff    <= !mem_empty;
      full_stage_ff     <= mem_full;
      // [R5] [R12] [R9] [R10] [R18] [R19] empty and full parked high in fall-through, input space parked low (free) in standard
      empty_flag_n_out  <= fall_through_mode_ff || empty_stage_ff;
      full_flag_n_out   <= fall_through_mode_ff || !full_stage_ff;
      input_space_n_out <= fall_through_mode_ff && full_stage_ff;
    end
  end

  // [R14] [R21] [R22] third stage of the fall-through chain, with data
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      output_ready_n_out <= ftm_pkg::FLAGS_RESET.out_ready_n;
    end else if (!mrs_n || !fall_through_mode_ff) begin
      output_ready_n_out <= ftm_pkg::FLAGS_RESET.out_ready_n;
    end else begin
      output_ready_n_out <= (nxt_ft_state != ftm_pkg::FTM_FT_VALID);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in || !mrs_n);

  mode_hold_a: assert property ($past(mrs_n) |-> $stable(fall_through_mode_ff)) // [R1]
    else $error("mode changed outside master reset");
  std_read_a: assert property (!fall_through_mode_ff && $past(mrs_n) && !$stable(data_out_out) |-> // [R2]
    $past(!rd_en_n_in && mem_cnt_ff != '0)) else $error("standard data moved without read");
  fall_thru_a: assert property (fall_through_mode_ff && ft_state_ff == ftm_pkg::FTM_FT_IDLE && // [R3]
    !mem_empty |-> ##3 !output_ready_n_out) else $error("first word not shown after three edges");
  wr_capture_a: assert property (wr_go |=> mem[$past(wr_ptr_ff)] == $past(wr_data_in)) // [R4]
    else $error("write data not stored");
  std_empty_a: assert property (!fall_through_mode_ff && $past(mrs_n, 2) |-> // [R5]
    empty_flag_n_out == ($past(mem_cnt_ff, 2) != '0)) else $error("empty flag not two stages behind");
  std_full_a: assert property (!fall_through_mode_ff && $past(mrs_n, 2) |-> // [R13]
    full_flag_n_out == ($past(mem_cnt_ff, 2) != CW'(DEPTH))) else $error("full flag not two stages behind");
  no_overflow_a: assert property (mem_full && !wr_en_n_in |=> mem_cnt_ff <= CW'(DEPTH)) // [R9]
    else $error("write accepted while full");
  ae_level_a: assert property ($past(mrs_n) |-> almost_empty_flag_n_out == // [R6]
    ($past(ftm_wide(level)) > $past(17'(empty_ofs_ff)) + $past(17'(fall_through_mode_ff))))
    else $error("almost-empty threshold wrong");
  half_level_a: assert property ($past(mrs_n) |-> half_level_flag_n_out == // [R7]
    !($past(ftm_wide(level)) > HALF17 + 17'(fall_through_mode_ff))) else $error("half flag threshold wrong");
  af_level_a: assert property ($past(mrs_n) |-> almost_full_flag_n_out == // [R8]
    !($past(ftm_wide(level)) + $past(17'(full_ofs_ff)) >= D17 + 17'(fall_through_mode_ff)))
    else $error("almost-full threshold wrong");
  ft_last_a: assert property (fall_through_mode_ff && rd_req && mem_empty |=> // [R21]
    output_ready_n_out ##1 output_ready_n_out) else $error("output ready kept after last read");
  ir_block_a: assert property (fall_through_mode_ff && $past(mrs_n, 2) |-> // [R18]
    input_space_n_out == ($past(mem_cnt_ff, 2) == CW'(DEPTH))) else $error("input space flag wrong");

  full_seen_c: cover property (mem_full ##1 rd_req);
  ft_first_c: cover property (fall_through_mode_ff && $fell(output_ready_n_out));
  std_drain_c: cover property (!fall_through_mode_ff && rd_req && mem_cnt_ff == CW'(1));
  offs_write_c: cover property (wb_hit && wb_we_in && wb_adr_in == ftm_pkg::ADR_EMPTY_OFS);

endmodule

// [ftm_fifo_flags_tb.sv]
// self-checking bench for the fifo timing modes and flags
`timescale 1ns/10ps
module ftm_fifo_flags_tb;
  localparam int unsigned D = ftm_pkg::DEF_DEPTH;
  localparam int unsigned N = 5;
  localparam int unsigned M = 6;
  logic        ref_clk_in = 1'b0;
  logic        rst_b_in   = 1'b0;
  logic        mrst_n, mode_sel, wr_en_n, rd_en_n;
  logic [35:0] wr_data, data_out;
  logic        ef_n, or_n, ff_n, is_n, hf_n, ae_n, af_n;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel, lanes;
  logic [31:0] wdat, rdat, tmp;
  int          fail_count = 0, cmp_count = 0, level = 0, rd_seq = 0;

  always #25 ref_clk_in = ~ref_clk_in;

  ftm_fifo_flags #(.DEPTH(D), .WIDTH(36)) u_ftm_fifo_flags (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .master_reset_n_in(mrst_n),
    .fall_through_select_serial_in_in(mode_sel), .wr_en_n_in(wr_en_n), .wr_data_in(wr_data),
    .rd_en_n_in(rd_en_n), .data_out_out(data_out), .empty_flag_n_out(ef_n), .output_ready_n_out(or_n),
    .full_flag_n_out(ff_n), .input_space_n_out(is_n), .half_level_flag_n_out(hf_n),
    .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack));

  ftm_far_side #(.WIDTH(36)) u_ftm_far_side (
    .ref_clk_in(ref_clk_in), .master_reset_n_out(mrst_n), .mode_sel_out(mode_sel),
    .wr_en_n_out(wr_en_n), .wr_data_out(wr_data), .rd_en_n_out(rd_en_n));

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic single cycle; held until ack is seen at an edge
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= lanes;
    wdat <= d;
    do @(posedge ref_clk_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  function automatic ftm_pkg::ftm_flags_t exp_flags(input int c, input logic ft);
    ftm_pkg::ftm_flags_t e;
    e.in_space_n     = ft && (c >= D + 1);
    e.out_ready_n    = !ft || (c == 0);
    e.full_n         = ft || (c < D);
    e.almost_full_n  = ft ? (c < D + 1 - M) : (c < D - M);
    e.half_n         = ft ? (c <= D / 2 + 1) : (c <= D / 2);
    e.almost_empty_n = ft ? (c >= N + 2) : (c >= N + 1);
    e.empty_n        = ft || (c > 0);
    return e;
  endfunction

  // flags on the pins, in the status register, and the level register
  task automatic check_flags(input logic ft);
    ftm_pkg::ftm_flags_t e;
    e = exp_flags(level, ft);
    repeat (ftm_pkg::SYNC_STAGES + ftm_pkg::FT_STAGES) @(posedge ref_clk_in);
    check({29'h0, is_n, or_n, ff_n, af_n, hf_n, ae_n, ef_n}, {29'h0, e});
    wb_cycle(1'b0, ftm_pkg::ADR_STATUS, 32'h0, tmp);
    check({28'h0, tmp[7:0]}, {28'h0, ft, e});
    wb_cycle(1'b0, ftm_pkg::ADR_LEVEL, 32'h0, tmp);
    check({4'h0, tmp}, 36'(level));
  endtask

  task automatic fill_to(input int t, input logic ft);
    u_ftm_far_side.write_words(t - level);
    level = t;
    check_flags(ft);
  endtask

  // reads in stored order; fall-through shows the head before the read
  task automatic drain_to(input int t, input logic ft);
    while (level > t) begin
      if (ft) check(data_out, {4'h5, 32'(rd_seq)});
      u_ftm_far_side.read_one();
      @(posedge ref_clk_in);
      if (!ft) check(data_out, {4'h5, 32'(rd_seq)});
      rd_seq++;
      level--;
    end
    check_flags(ft);
  endtask

  // defaults after master reset, unmapped place, then program offsets
  task automatic offsets_check();
    wb_cycle(1'b0, ftm_pkg::ADR_EMPTY_OFS, 32'h0, tmp);
    check({4'h0, tmp}, {20'h0, ftm_pkg::DEF_OFFSET}); // empty offset reload
    wb_cycle(1'b0, ftm_pkg::ADR_FULL_OFS, 32'h0, tmp);
    check({4'h0, tmp}, {20'h0, ftm_pkg::DEF_OFFSET}); // full offset reload
    wb_cycle(1'b1, 8'h40, 32'h0000_ffff, tmp);
    wb_cycle(1'b0, 8'h40, 32'h0, tmp);
    check({4'h0, tmp}, {4'h0, ftm_pkg::RD_UNMAPPED});
    // upper lane alone must leave the low byte at its default
    lanes = 4'h2;
    wb_cycle(1'b1, ftm_pkg::ADR_EMPTY_OFS, 32'h0000_33cc, tmp);
    lanes = 4'h3;
    wb_cycle(1'b0, ftm_pkg::ADR_EMPTY_OFS, 32'h0, tmp);
    check({4'h0, tmp}, {20'h0, 8'h33, ftm_pkg::DEF_OFFSET[7:0]}); // byte lanes
    wb_cycle(1'b1, ftm_pkg::ADR_EMPTY_OFS, 32'(N), tmp);
    wb_cycle(1'b1, ftm_pkg::ADR_FULL_OFS, 32'(M), tmp);
    wb_cycle(1'b0, ftm_pkg::ADR_FULL_OFS, 32'h0, tmp);
    check({4'h0, tmp}, 36'(M)); // offset writable
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_standard();
    u_ftm_far_side.mreset(1'b0); // standard selected
    rd_seq = u_ftm_far_side.wr_seq;
    level  = 0;
    offsets_check();
    u_ftm_far_side.read_one();
    check_flags(1'b0); // read on empty ignored
    u_ftm_far_side.write_words(1);
    repeat (2) @(posedge ref_clk_in);
    check({35'h0, ef_n}, 36'h0); // empty lags two stages
    @(posedge ref_clk_in);
    check({35'h0, ef_n}, 36'h1); // empty released
    level = 1;
    fill_to(N, 1'b0); // almost-empty still low at n
    fill_to(N + 1, 1'b0); // almost-empty threshold
    fill_to(D / 2, 1'b0); // half not yet
    fill_to(D / 2 + 1, 1'b0); // half crossed
    fill_to(D - M - 1, 1'b0); // almost-full not yet
    fill_to(D - M, 1'b0); // almost-full reached
    fill_to(D, 1'b0); // full at depth
    u_ftm_far_side.write_words(3);
    check_flags(1'b0); // writes while full ignored
    drain_to(D - 1, 1'b0); // first read frees
    drain_to(N + 1, 1'b0); // above empty offset
    drain_to(N, 1'b0); // almost-empty at n
    drain_to(0, 1'b0); // last read empties
    $display("test standard done, mismatches %0d", fail_count);
  endtask

  task automatic test_fall_through();
    u_ftm_far_side.mreset(1'b1);
    rd_seq = u_ftm_far_side.wr_seq;
    level  = 0;
    check_flags(1'b1); // fall-through selected
    offsets_check();
    u_ftm_far_side.read_one();
    check_flags(1'b1); // read on empty ignored
    u_ftm_far_side.write_words(1);
    repeat (3) @(posedge ref_clk_in);
    check({35'h0, or_n}, 36'h1); // ready not before third edge
    @(posedge ref_clk_in);
    check({35'h0, or_n}, 36'h0); // output ready low
    check(data_out, {4'h5, 32'(rd_seq)}); // first word falls through
    level = 1;
    fill_to(N + 1, 1'b1); // below threshold
    fill_to(N + 2, 1'b1); // almost-empty high
    fill_to(D / 2 + 1, 1'b1); // half not yet
    fill_to(D / 2 + 2, 1'b1); // half crossed
    fill_to(D - M, 1'b1); // almost-full not yet
    fill_to(D + 1 - M, 1'b1); // almost-full reached
    fill_to(D, 1'b1); // one word of space left
    fill_to(D + 1, 1'b1); // input blocked
    u_ftm_far_side.write_words(3);
    check_flags(1'b1); // writes while blocked ignored
    drain_to(D, 1'b1); // first read frees input
    drain_to(N + 2, 1'b1); // above threshold
    drain_to(N + 1, 1'b1); // almost-empty low
    drain_to(0, 1'b1); // last read clears ready
    $display("test fall-through done, mismatches %0d", fail_count);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence; bus idles low until the first request
  initial begin
    cyc   <= 1'b0;
    stb   <= 1'b0;
    we    <= 1'b0;
    adr   <= 8'h00;
    sel   <= 4'h0;
    wdat  <= 32'h0000_0000;
    lanes = 4'h3;
    repeat (5) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    test_standard();
    test_fall_through();
    give_verdict();
  end

  // watchdog sized well above both fill and drain passes
  initial begin
    #(50 * 40000);
    fail_count++;
    give_verdict();
  end
endmodule

// [ftm_pkg.sv]
// shared constants and types for the fifo timing-mode and flag block
package ftm_pkg;

  // ****************************************
  // geometry defaults
  // ****************************************
  localparam int unsigned DEF_DEPTH = 1024;
  localparam int unsigned DEF_WIDTH = 36;
  localparam int unsigned MIN_DEPTH = 1024;
  localparam int unsigned MAX_DEPTH = 32768;

  // ****************************************
  // timing counts in clock edges
  // ****************************************
  localparam int unsigned SYNC_STAGES = 2;   // std empty/full, fall_through_mode input space
  localparam int unsigned FT_STAGES   = 3;   // fall_through_mode first word and output ready

  // ****************************************
  // register map (byte addresses) and resets
  // ****************************************
  localparam logic [7:0]  ADR_EMPTY_OFS = 8'h00;
  localparam logic [7:0]  ADR_FULL_OFS  = 8'h04;
  localparam logic [7:0]  ADR_STATUS    = 8'h08;
  localparam logic [7:0]  ADR_LEVEL     = 8'h0c;
  localparam logic [15:0] DEF_OFFSET    = 16'h007f;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  // fall-through output stage; wait states make the three-edge delay
  typedef enum logic [1:0] {
    FTM_FT_IDLE  = 2'b00,
    FTM_FT_W1    = 2'b01,
    FTM_FT_W2    = 2'b10,
    FTM_FT_VALID = 2'b11
  } ftm_ft_state_t;

  // flag pins, all active low, as one carrier
  typedef struct packed {
    logic in_space_n;
    logic out_ready_n;
    logic full_n;
    logic almost_full_n;
    logic half_n;
    logic almost_empty_n;
    logic empty_n;
  } ftm_flags_t;

  // reset view: empty, not full, output not ready, input space free
  localparam ftm_flags_t FLAGS_RESET = '{
    in_space_n: 1'b0, out_ready_n: 1'b1, full_n: 1'b1, almost_full_n: 1'b1,
    half_n: 1'b1, almost_empty_n: 1'b0, empty_n: 1'b0};

  // status register content
  typedef struct packed {
    logic       fall_through_mode;
    ftm_flags_t flags;
  } ftm_status_t;

endpackage
